/* design/osp_otp_space.sv */
// OTP space and parameter table access block with AHB-Lite registers
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module osp_otp_space (
    input  wire logic                      MCLK,
    input  wire logic                      ARST_N,
    input  wire logic                      HSEL,
    input  wire logic [osp_pkg::DATA_W-1:0] HADDR,
    input  wire logic [1:0]                HTRANS,
    input  wire logic                      HWRITE,
    input  wire logic [2:0]                HSIZE,
    input  wire logic [osp_pkg::DATA_W-1:0] HWDATA,
    input  wire logic                      HREADY,
    output logic [osp_pkg::DATA_W-1:0]     HRDATA,
    output logic                           HREADYOUT,
    output logic                           HRESP,
    output logic                           BUSY,
    output logic                           PROG_ERR,
    output logic                           FREEZE
);
    import osp_pkg::*;

    // ==================================================
    // Storage
    // No reset on the array: content must survive resets
    logic [7:0]        mem [0:OTP_BYTES-1];
    logic [OTP_AW-1:0] otp_addr;
    logic [7:0]        wr_byte;
    logic [7:0]        rd_byte;
    logic [6:0]        cfg_vol;
    logic              freeze;
    logic              prog_err;
    logic              wr_pend;
    logic [7:0]        wr_off;
    logic [OTP_AW-1:0] pend_addr;
    logic [7:0]        pend_data;
    logic [REGIONS-1:0] lock_bits;
    logic              busy;
    logic              prog_done;
    logic              allow;
    logic              addr_ok;
    logic              cmd_go;
    logic [7:0]        opcode;
    logic              prog_req;
    logic              prog_start;
    logic              prog_rej;
    logic              soft_rst;
    logic              clr_stat;

    // ==================================================
    // Decoding helpers
    function automatic logic reg_hit(input logic [7:0] off,
                                     input logic [7:0] target);
        return off == target;
    endfunction

    function automatic logic [7:0] param_byte(
        input logic [OTP_AW-1:0] a);
        logic [7:0] v;
        v = ERASED_BYTE;
        if (a < 10'(PARAM_BYTES))
            v = PARAM_ROM[a[4:0]];                   // [R1] [R3]
        return v;
    endfunction

    // ==================================================
    // Delivery state
    // Models factory content; ignored by synthesis of a real macro
    initial begin
        for (int i = 0; i < OTP_BYTES; i++)
            mem[i] = ERASED_BYTE;                    // [R11]
        for (int i = 0; i < RAND_BYTES; i++)
            mem[i] = RAND_VALUE[8*i +: 8];           // [R7]
    end

    // ==================================================
    // Bus address phase
    assign addr_ok = HSEL && HREADY && HTRANS[1];

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_pend <= 1'b0;
            wr_off  <= 8'h00;
        end else begin
            wr_pend <= addr_ok && HWRITE;
            wr_off  <= HADDR[7:0];
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // Read data captured at the address phase edge
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            HRDATA <= 32'h0000_0000;
            if (reg_hit(HADDR[7:0], REG_ADDR))
                HRDATA <= {22'h0, otp_addr};
            else if (reg_hit(HADDR[7:0], REG_WDATA))
                HRDATA <= {24'h0, wr_byte};
            else if (reg_hit(HADDR[7:0], REG_RDATA))
                HRDATA <= {24'h0, rd_byte};
            else if (reg_hit(HADDR[7:0], REG_STATUS))
                HRDATA <= {30'h0, prog_err, busy};
            else if (reg_hit(HADDR[7:0], REG_CONFIG))
                HRDATA <= {24'h0, cfg_vol, freeze};  // [R14]
        end
    end

    // ==================================================
    // Command decode
    assign cmd_go     = wr_pend && reg_hit(wr_off, REG_CMD) && !busy;
    assign opcode     = HWDATA[7:0];
    assign prog_req   = cmd_go && (opcode == OP_OTP_PROG);
    assign prog_start = prog_req && allow;
    assign prog_rej   = prog_req && !allow;
    assign soft_rst   = cmd_go && (opcode == OP_SOFT_RESET);
    assign clr_stat   = cmd_go && (opcode == OP_CLEAR_STATUS);

    // ==================================================
    // Protection
    // Lock bits come straight from the array, so a new lock
    // applies to any program command issued after the completion edge
    assign lock_bits = {mem[LOCK_BASE + 10'd3], mem[LOCK_BASE + 10'd2],
                        mem[LOCK_BASE + 10'd1], mem[LOCK_BASE]}; // [R8]

    osp_prog_guard u_guard (
        .addr   (otp_addr),
        .lock   (lock_bits),
        .freeze (freeze),
        .allow  (allow)
    );

    osp_prog_timer u_timer (
        .clk   (MCLK),
        .rst_n (ARST_N),
        .start (prog_start),
        .busy  (busy),
        .done  (prog_done)
    );

    // ==================================================
    // Software-written registers
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            otp_addr <= ADDR_RESET;
            wr_byte  <= BYTE_RESET;
        end else if (soft_rst) begin
            otp_addr <= ADDR_RESET;                  // [R15]
            wr_byte  <= BYTE_RESET;
        end else if (wr_pend) begin
            if (reg_hit(wr_off, REG_ADDR))
                otp_addr <= HWDATA[OTP_AW-1:0];      // [R4]
            if (reg_hit(wr_off, REG_WDATA))
                wr_byte <= HWDATA[7:0];
        end
    end

    // Volatile config bits follow every reset
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N)
            cfg_vol <= CFG_RESET;
        else if (soft_rst)
            cfg_vol <= CFG_RESET;                    // [R15]
        else if (wr_pend && reg_hit(wr_off, REG_CONFIG))
            cfg_vol <= HWDATA[7:1];                  // [R14]
    end

    // Freeze can only be set; soft reset leaves it alone
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N)
            freeze <= 1'b0;
        else if (wr_pend && reg_hit(wr_off, REG_CONFIG)
                 && HWDATA[CFG_FREEZE])
            freeze <= 1'b1;                          // [R13]
    end

    // ==================================================
    // Read commands
    // A read issued on the completion edge sees the old byte
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N)
            rd_byte <= BYTE_RESET;
        else if (soft_rst)
            rd_byte <= BYTE_RESET;                   // [R15]
        else if (cmd_go && opcode == OP_READ_PARAMS)
            rd_byte <= param_byte(otp_addr);         // [R1] [R2]
        else if (cmd_go && opcode == OP_OTP_READ)
            rd_byte <= mem[otp_addr];                // [R4]
    end

    // ==================================================
    // Program path
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pend_addr <= ADDR_RESET;
            pend_data <= ERASED_BYTE;
        end else if (prog_start) begin
            pend_addr <= otp_addr;
            pend_data <= wr_byte;
        end
    end

    // Only clears bits, so a lock bit once zero stays zero
    always @(posedge MCLK) begin                     // [R16]
        if (prog_done)
            mem[pend_addr] <= mem[pend_addr] & pend_data; // [R18] [R10]
    end

    // Error flag: a new refusal wins over a clear
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N)
            prog_err <= 1'b0;
        else if (prog_rej)
            prog_err <= 1'b1;                        // [R17]
        else if (clr_stat || soft_rst)
            prog_err <= 1'b0;                        // [R15]
    end

    assign BUSY     = busy;
    assign PROG_ERR = prog_err;
    assign FREEZE   = freeze;

    // ==================================================
    // Checks
    // Byte before the program, to show that no bit rises
    logic [OTP_AW-1:0] chk_addr;
    logic [7:0]        chk_exp;
    logic [7:0]        chk_old;
    logic              chk_en;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            chk_en   <= 1'b0;
            chk_addr <= ADDR_RESET;
            chk_exp  <= ERASED_BYTE;
            chk_old  <= ERASED_BYTE;
        end else begin
            chk_en   <= prog_done;
            chk_addr <= pend_addr;
            chk_exp  <= mem[pend_addr] & pend_data;
            chk_old  <= mem[pend_addr];
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    a_param_read: assert property ( // [R1]
        cmd_go && opcode == OP_READ_PARAMS
        |=> rd_byte == param_byte(otp_addr))
        else $error("parameter read returned wrong byte");

    a_rand_refused: assert property ( // [R6]
        prog_req && otp_addr <= RAND_LAST
        |=> PROG_ERR && !BUSY)
        else $error("random number byte was programmable");

    a_freeze_blocks: assert property ( // [R12]
        prog_req && freeze |=> PROG_ERR && !BUSY)
        else $error("program accepted while frozen");

    a_freeze_sticky: assert property ( // [R13]
        $past(freeze) |-> FREEZE)
        else $error("freeze bit dropped");

    a_lock_blocks: assert property ( // [R8]
        prog_req && !lock_bits[otp_addr[9:5]]
        |=> $rose(PROG_ERR) || $past(prog_err))
        else $error("locked region accepted a program");

    a_rfu_accepts: assert property ( // [R10]
        prog_req && !freeze && lock_bits[0]
        && otp_addr >= RFU_BASE && otp_addr <= RFU_LAST
        |=> BUSY ##[1:16] prog_done)
        else $error("reserved byte refused");

    a_only_clears: assert property ( // [R18]
        chk_en |-> mem[chk_addr] == chk_exp
        && (mem[chk_addr] & ~chk_old) == 8'h00)
        else $error("program set a bit back to one");

    a_soft_reset: assert property ( // [R15]
        soft_rst |=> !PROG_ERR && rd_byte == BYTE_RESET
        && FREEZE == $past(freeze))
        else $error("soft reset left volatile state");

    a_prog_time: assert property ( // [R17]
        prog_start |-> ##[10:11] prog_done)
        else $error("program time wrong");

    a_bus_okay: assert property ( // [R14]
        HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");

    a_clear_status: assert property ( // [R17]
        clr_stat |=> !PROG_ERR)
        else $error("clear left the error flag set");

    a_accept_busy: assert property ( // [R5]
        prog_start |=> BUSY && $stable(PROG_ERR))
        else $error("accepted program did not start");

    a_err_sticky: assert property ( // [R17]
        PROG_ERR && !clr_stat && !soft_rst |=> PROG_ERR)
        else $error("error flag dropped without a clear");

    a_param_beyond: assert property ( // [R1]
        cmd_go && opcode == OP_READ_PARAMS
        && otp_addr >= 10'(PARAM_BYTES)
        |=> rd_byte == ERASED_BYTE)
        else $error("parameter read past table not erased");

    a_freeze_set: assert property ( // [R12]
        wr_pend && reg_hit(wr_off, REG_CONFIG) && HWDATA[CFG_FREEZE]
        |=> FREEZE)
        else $error("freeze bit did not set");

    a_soft_regs: assert property ( // [R15]
        soft_rst |=> otp_addr == ADDR_RESET && wr_byte == BYTE_RESET
        && cfg_vol == CFG_RESET)
        else $error("soft reset left a register");

    a_unmapped_zero: assert property ( // [R14]
        addr_ok && !HWRITE
        && (HADDR[7:0] == REG_CMD || HADDR[7:0] > REG_CONFIG)
        |=> HRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    c_prog_done: cover property (prog_start ##[1:16] prog_done);
    c_prog_rej:  cover property (prog_rej);
    c_param_rd:  cover property (cmd_go && opcode == OP_READ_PARAMS);
    c_frozen:    cover property ($rose(freeze));
    c_soft_rst:  cover property (soft_rst);
endmodule
`default_nettype wire

/* design/osp_pkg.sv */
// Constants, register map and parameter table for the OTP space block
// Functional notes
// (R1) Opcode 5a reads the discoverable-parameter table, not the OTP array.
// (R2) The parameter table is fixed content; nothing can change it.
// (R3) The parameter table carries the ID-CFI data as one parameter table.
// (R4) The OTP space holds 1024 bytes with its own 10-bit address.
// (R5) Thirty-two regions of 32 aligned bytes, each lockable on its own.
// (R6) Bytes 000 to 00F hold a factory random number; programming refused.
// (R7) Random number is little-endian: low byte at 000, high at 00F.
// (R8) Bytes 010 to 013 hold one lock bit per region; zero blocks.
// (R9) The host locks a region by programming its lock bit to zero.
// (R10) Reserved bytes 014 to 01F program like ordinary OTP bytes.
// (R11) As delivered, lock, reserved and region 1-31 bytes all read ff.
// (R12) Freeze bit set blocks all OTP programming regardless of lock bits.
// (R13) Freeze, once set, holds until the next power-on.
// (R14) Config and status only through their own registers, not OTP addresses.
// (R15) Volatile bits return to defaults on hardware and software reset.
// (R16) OTP and non-volatile content survives every reset.
// (R17) Programming a locked or protected byte is refused and flags an error.
// (R18) Programming only clears bits; a cleared bit never returns to one.
package osp_pkg;
    // ==================================================
    // Widths and OTP geometry
    localparam int DATA_W       = 32;
    localparam int OTP_BYTES    = 1024;
    localparam int OTP_AW       = 10;
    localparam int REGIONS      = 32;
    localparam int RAND_BYTES   = 16;
    localparam logic [9:0] RAND_LAST = 10'h00f;
    localparam logic [9:0] LOCK_BASE = 10'h010;
    localparam logic [9:0] RFU_BASE  = 10'h014;
    localparam logic [9:0] RFU_LAST  = 10'h01f;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // Factory random number, value arbitrary
    localparam logic [127:0] RAND_VALUE =
        128'h9e3779b97f4a7c15f39cc0605cedc834;
    // ==================================================
    // Command opcodes
    localparam logic [7:0] OP_READ_PARAMS  = 8'h5a;
    localparam logic [7:0] OP_OTP_READ     = 8'h4b;
    localparam logic [7:0] OP_OTP_PROG     = 8'h42;
    localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] OP_SOFT_RESET   = 8'hf0;
    // ==================================================
    // Register offsets, field positions, reset values
    localparam logic [7:0] REG_ADDR   = 8'h00;
    localparam logic [7:0] REG_WDATA  = 8'h04;
    localparam logic [7:0] REG_CMD    = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CONFIG = 8'h14;
    localparam int ST_BUSY = 0;
    localparam int ST_PERR = 1;
    localparam int CFG_FREEZE = 0;
    localparam logic [6:0] CFG_RESET  = 7'h00;
    localparam logic [9:0] ADDR_RESET = 10'h000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // ==================================================
    // Timing
    localparam int CLK_PERIOD_NS    = 40;
    localparam int OTP_PROG_TIME_NS = 400;
    localparam int PROG_CYCLES =
        (OTP_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] PROG_CNT = 8'(PROG_CYCLES);
    // ==================================================
    // Parameter table; codes arbitrary
    localparam logic [7:0] MFR_CODE = 8'h5c;
    localparam logic [7:0] DEV_CODE = 8'h3e;
    localparam logic [7:0] IDCFI_ID = 8'h81;
    localparam int PARAM_BYTES = 24;
    localparam logic [7:0] PARAM_ROM [0:PARAM_BYTES-1] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hff,
        IDCFI_ID, 8'h00, 8'h01, 8'h02, 8'h10, 8'h00, 8'h00, 8'hff,
        MFR_CODE, DEV_CODE, 8'h51, 8'h52, 8'h59, 8'hff, 8'hff, 8'hff};
endpackage

/* design/osp_prog_guard.sv */
// Decides whether an OTP byte may be programmed
`timescale 1ns/1ps
`default_nettype none
module osp_prog_guard (
    input  wire logic [osp_pkg::OTP_AW-1:0]  addr,
    input  wire logic [osp_pkg::REGIONS-1:0] lock,
    input  wire logic                        freeze,
    output logic                             allow
);
    import osp_pkg::*;

    logic [4:0] region;

    // ==================================================
    // Protection decision
    always_comb begin
        region = addr[9:5];                          // [R5]
        allow  = !freeze                             // [R12]
              && lock[region]                        // [R8]
              && (addr > RAND_LAST);                 // [R6]
    end
endmodule
`default_nettype wire

/* design/osp_prog_timer.sv */
// Busy timer for one OTP program operation
`timescale 1ns/1ps
`default_nettype none
module osp_prog_timer (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    import osp_pkg::*;

    typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} osp_tmr_t;
    osp_tmr_t   state;
    logic [7:0] count;

    // ==================================================
    // Sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            count <= 8'h00;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_RUN;
                        count <= PROG_CNT - 8'h01;
                    end
                end
                ST_RUN: begin
                    if (count == 8'h00) begin
                        state <= ST_IDLE;
                        done  <= 1'b1;
                    end else begin
                        count <= count - 8'h01;
                    end
                end
            endcase
        end
    end

    assign busy = (state == ST_RUN);
endmodule
`default_nettype wire

/* tb/osp_ahb_host.sv */
// AHB-Lite host model driving the OTP block registers
`timescale 1ns/1ps
`default_nettype none
module osp_ahb_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0;
    end
    // ==================================================
    // One word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hwdata <= ~hwdata;  // Stale data must never look valid
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
endmodule
`default_nettype wire

/* tb/osp_otp_space_tb_top.sv */
// Self-checking bench for the OTP space protection block
`timescale 1ns/1ps
`default_nettype none
module osp_otp_space_tb_top;
    import osp_pkg::*;
    logic        mclk, arst_n, hsel, hwrite, hrdy, hresp, busy, perr, frz_o;
    logic [31:0] haddr, hwdata, hrdata, rd, rnd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  mdl [0:OTP_BYTES-1];
    logic [9:0]  a;
    logic [4:0]  r;
    logic        frz;
    int          err_count, num_checks, cycles, seed, i;

    osp_otp_space dut (.MCLK(mclk), .ARST_N(arst_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
        .HREADYOUT(hrdy), .HRESP(hresp), .BUSY(busy), .PROG_ERR(perr),
        .FREEZE(frz_o));
    osp_ahb_host host (.hclk(mclk), .hready(hrdy), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // ==================================================
    // Hang guard, well above the expected run
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            $display("wrong value at %0t: timeout", $time);
            give_verdict();
        end
    end
    // ==================================================
    // Checks and verdict
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e,
                            input string w);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: %s %h not %h", $time, w, g, e);
        end
    endtask
    task automatic chk_flag(input logic g, input logic e, input string w);
        chk_word({31'h0, g}, {31'h0, e}, w);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==================================================
    // Register access and commands
    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        logic [31:0] x;
        host.xfer(1'b1, ad, v, x);
    endtask
    task automatic rdr(input logic [7:0] ad, output logic [31:0] v);
        host.xfer(1'b0, ad, 32'h0, v);
    endtask
    task automatic cmd(input logic [7:0] op);
        wr(REG_CMD, {24'h0, op});
        @(posedge mclk);  // Result lands on the data-phase edge of the command write
    endtask
    task automatic fetch(input logic [7:0] op, input logic [9:0] ad,
                         output logic [31:0] v);
        wr(REG_ADDR, {22'h0, ad});
        cmd(op);
        rdr(REG_RDATA, v);
    endtask
    // Expected outcome from freeze, random bytes and lock bits
    function automatic logic may_prog(input logic [9:0] ad);
        logic [4:0] g;
        g = ad[9:5];
        return !frz && ad > RAND_LAST && mdl[{8'h04, g[4:3]}][g[2:0]];
    endfunction
    task automatic prog(input logic [9:0] ad, input logic [7:0] v);
        logic        ok;
        logic [31:0] s;
        int          n;
        ok = may_prog(ad);
        n = 0;
        wr(REG_ADDR, {22'h0, ad});
        wr(REG_WDATA, {24'h0, v});
        cmd(OP_OTP_PROG);
        rdr(REG_STATUS, s);
        chk_word(s, {30'h0, !ok, ok}, "prog status");
        chk_flag(perr, !ok, "perr pin");
        chk_flag(busy, ok, "busy pin");
        while (s[0] === 1'b1 && n < 50) begin
            rdr(REG_STATUS, s);
            n++;
        end
        chk_flag(s[0], 1'b0, "busy end");
        if (ok) begin
            mdl[ad] = mdl[ad] & v;  // Bits only ever clear
        end else begin
            cmd(OP_CLEAR_STATUS);
            rdr(REG_STATUS, s);
            chk_word(s, 32'h0, "status clear");
        end
        fetch(OP_OTP_READ, ad, s);
        chk_word(s, {24'h0, mdl[ad]}, "otp byte");
    endtask
    task automatic param_scan();
        for (i = 0; i <= PARAM_BYTES; i++) begin
            fetch(OP_READ_PARAMS, 10'(i), rd);
            chk_word(rd, {24'h0, i < PARAM_BYTES ? PARAM_ROM[i] :
                     8'hff}, "param");
        end
    endtask
    // ==================================================
    // Main sequence
    initial begin
        seed = 32'hc31bc586;
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        frz = 1'b0;
        arst_n = 1'b0;
        for (i = 0; i < OTP_BYTES; i++) begin
            mdl[i] = i < RAND_BYTES ? RAND_VALUE[8*i +: 8] : ERASED_BYTE;
        end
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        chk_flag(frz_o, 1'b0, "freeze reset");
        rdr(REG_STATUS, rd);
        chk_word(rd, 32'h0, "status reset");
        rdr(REG_CONFIG, rd);
        chk_word(rd, 32'h0, "config reset");
        rdr(8'h40, rd);
        chk_word(rd, 32'h0, "unmapped");
        chk_flag(hresp, 1'b0, "okay");
        param_scan();
        $display("test reset and params done");
        for (i = 0; i < 64; i++) begin
            rnd = $random(seed);
            a = i < 32 ? 10'(i) : rnd[9:0];
            fetch(OP_OTP_READ, a, rd);
            chk_word(rd, {24'h0, mdl[a]}, "delivery");
        end
        $display("test delivery done");
        prog(10'h000, 8'h00);
        prog(RAND_LAST, 8'h00);
        for (i = 0; i < 12; i++) begin
            rnd = $random(seed);
            a = 10'h020 + 10'(rnd[30:0] % 992);
            prog(a, rnd[31:24]);
            prog(a, 8'hff);
            prog(RFU_BASE + 10'(rnd[15:8] % 12), rnd[7:0]);
        end
        $display("test program done");
        prog(10'h013, 8'h7f);
        prog(10'h3ff, 8'h00);
        prog(10'h3df, 8'h00);
        rnd = $random(seed);
        r = 5'd1 + 5'(rnd[7:0] % 30);
        prog({8'h04, r[4:3]}, ~(8'h01 << r[2:0]));
        prog({r, rnd[12:8]}, 8'h00);
        $display("test lock done");
        wr(REG_CONFIG, 32'hfe);
        rdr(REG_CONFIG, rd);
        chk_word(rd, 32'hfe, "config rw");
        wr(REG_ADDR, 32'h0);
        cmd(OP_OTP_PROG);
        chk_flag(perr, 1'b1, "perr set");
        cmd(OP_SOFT_RESET);
        rdr(REG_STATUS, rd);
        chk_word(rd, 32'h0, "soft status");
        rdr(REG_CONFIG, rd);
        chk_word(rd, 32'h0, "soft config");
        $display("test soft reset done");
        wr(REG_CONFIG, 32'h1);
        @(posedge mclk);  // Freeze lands on the data-phase edge
        frz = 1'b1;
        chk_flag(frz_o, 1'b1, "freeze set");
        prog(10'h3e0, 8'h00);
        wr(REG_CONFIG, 32'h0);
        cmd(OP_SOFT_RESET);
        rdr(REG_CONFIG, rd);
        chk_word(rd, 32'h1, "freeze held");
        prog(10'h020, 8'h00);
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        frz = 1'b0;
        chk_flag(frz_o, 1'b0, "freeze power");
        for (i = 0; i < OTP_BYTES; i++) begin
            fetch(OP_OTP_READ, 10'(i), rd);
            chk_word(rd, {24'h0, mdl[i]}, "kept");
        end
        prog(10'h3e0, 8'h00);
        param_scan();
        $display("test freeze and retention done");
        give_verdict();
    end
endmodule
`default_nettype wire
